// >>> design/mrtf_params.svh
// constants for the media root thread front end
`ifndef MRTF_PARAMS_SVH
`define MRTF_PARAMS_SVH
`define MRTF_DW 32
`define MRTF_ADDR_W 32
`define MRTF_WIDE_W 256
`define MRTF_HANDLE_W 8
`define MRTF_POOL_DEPTH 16
`define MRTF_POOL_IDX_W 4
`define MRTF_CNT_W 5
`define MRTF_DESC_SIZE 32'h00000020
`define MRTF_WORDS_PER_BEAT 8
`define MRTF_BEAT_IDX_W 3
`endif

// >>> design/mrtf_pkg.sv
// types shared by the front end and its testbench
`default_nettype none
`include "mrtf_params.svh"
package mrtf_pkg;
  typedef enum logic [1:0] {
    MRTF_MODE_GENERIC,
    MRTF_MODE_INV_SCAN,
    MRTF_MODE_VAR_LEN
  } mrtf_mode_t;
  // state command contents
  typedef struct packed {
    mrtf_mode_t mode;
    logic [`MRTF_ADDR_W-1:0] desc_base;
    logic [`MRTF_ADDR_W-1:0] scratch_base;
    logic [`MRTF_DW-1:0] scratch_cfg;
    logic [`MRTF_CNT_W-1:0] handle_count;
    logic [`MRTF_HANDLE_W-1:0] handle_len;
    logic [`MRTF_HANDLE_W-1:0] const_handle;
  } mrtf_state_t;
  // one thread handed to the spawner
  typedef struct packed {
    logic [`MRTF_ADDR_W-1:0] desc_ptr;
    logic [`MRTF_HANDLE_W-1:0] handle;
    logic [`MRTF_HANDLE_W-1:0] const_handle;
    logic [`MRTF_ADDR_W-1:0] scratch_base;
    logic [`MRTF_DW-1:0] scratch_cfg;
  } mrtf_thread_t;
  // one wide write into the return buffer
  typedef struct packed {
    logic [`MRTF_HANDLE_W-1:0] handle;
    logic [`MRTF_HANDLE_W-1:0] beat;
    logic [`MRTF_WIDE_W-1:0] data;
  } mrtf_wide_t;
endpackage : mrtf_pkg
`default_nettype wire

// >>> design/mrtf_handle_pool.sv
// circular pool of return buffer handles
`default_nettype none
`include "mrtf_params.svh"
module mrtf_handle_pool (
  // clock and reset
  input wire logic I_CLK,
  input wire logic I_NRST,
  input wire logic i_ce,
  // refill from the buffer manager
  input wire logic i_flush,
  input wire logic i_load_valid,
  input wire logic [`MRTF_HANDLE_W-1:0] i_load_handle,
  // take and release
  input wire logic i_take,
  input wire logic i_release,
  input wire logic [`MRTF_HANDLE_W-1:0] i_release_handle,
  output logic o_avail,
  output logic [`MRTF_HANDLE_W-1:0] o_head_handle
);
  logic [`MRTF_HANDLE_W-1:0] slot [`MRTF_POOL_DEPTH];
  logic [`MRTF_POOL_DEPTH-1:0] busy;
  logic [`MRTF_POOL_DEPTH-1:0] used;
  logic [`MRTF_POOL_IDX_W-1:0] head;
  logic [`MRTF_POOL_IDX_W-1:0] fill;
  logic [`MRTF_CNT_W-1:0] size;
  logic [`MRTF_POOL_IDX_W-1:0] next_head;

  assign o_avail = used[head] && !busy[head];
  assign o_head_handle = slot[head];
  always_comb begin
    next_head = head + 4'h1;
    if ({1'b0, next_head} >= size) begin
      next_head = 4'h0;
    end
  end

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      fill <= 4'h0;
      size <= 5'h00;
      used <= '0;
      for (int k = 0; k < `MRTF_POOL_DEPTH; k++) begin
        slot[k] <= 8'h00;
      end
    end else if (i_ce) begin
      if (i_flush) begin
        fill <= 4'h0;
        size <= 5'h00;
        used <= '0;
      end else if (i_load_valid && size < 5'h10) begin
        slot[fill] <= i_load_handle;
        used[fill] <= 1'b1;
        fill <= fill + 4'h1;
        size <= size + 5'h01;
      end
    end
  end

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      head <= 4'h0;
    end else if (i_ce) begin
      if (i_flush) begin
        head <= 4'h0;
      end else if (i_take && o_avail) begin
        head <= next_head;
      end
    end
  end

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      busy <= '0;
    end else if (i_ce) begin
      if (i_flush) begin
        busy <= '0;
      end else begin
        for (int k = 0; k < `MRTF_POOL_DEPTH; k++) begin
          if (i_release && used[k] && slot[k] == i_release_handle) begin
            busy[k] <= 1'b0;
          end
        end
        // take wins over a same-cycle release of the head slot
        if (i_take && o_avail) begin
          busy[head] <= 1'b1;
        end
      end
    end
  end

  property p_take_marks_busy;
    @(posedge I_CLK) disable iff (!I_NRST)
      (i_ce && i_take && o_avail && !i_flush) |=> busy[$past(head)];
  endproperty
  a_take_marks_busy: assert property (p_take_marks_busy)
    else $error("taken handle not marked busy");

  property p_head_steps;
    @(posedge I_CLK) disable iff (!I_NRST)
      (i_ce && i_take && o_avail && !i_flush) |=> head == $past(next_head);
  endproperty
  a_head_steps: assert property (p_head_steps)
    else $error("head did not advance in order");
endmodule : mrtf_handle_pool
`default_nettype wire

// >>> design/mrtf_front_end.sv
// front end unit: builds one root thread per primitive command
// Operation
// - generic mode: one thread per command
// - three modes, chosen by state command
// - decode and scan modes take every payload dword
// - hand descriptor and handle to spawner
// - forward the constant handle
// - forward scratch config with descriptor
// - latch state at first primitive
// - allocate handles on every state change
// - take handles from head in order
// - exactly one handle per thread
// - handle holds payload, later return space
// - release frees handle for reuse
// - payload goes out on wide bus
// - pointer is base plus offset times size
// - state command discards and regenerates handles
`default_nettype none
`include "mrtf_params.svh"
module mrtf_front_end
  import mrtf_pkg::*;
(
  // clock, reset, enable
  input wire logic I_CLK,
  input wire logic I_NRST,
  input wire logic I_CE,
  // state command from the streamer
  input wire logic I_STATE_VALID,
  input wire mrtf_pkg::mrtf_state_t I_STATE,
  // primitive command header
  input wire logic I_CMD_VALID,
  output logic O_CMD_READY,
  input wire logic [`MRTF_DW-1:0] I_CMD_DESC_OFFSET,
  // payload dwords, last marks end of command
  input wire logic I_DW_VALID,
  output logic O_DW_READY,
  input wire logic [`MRTF_DW-1:0] I_DW,
  input wire logic I_DW_LAST,
  // handles from the buffer manager
  output logic O_ALLOC_REQ,
  input wire logic I_ALLOC_VALID,
  input wire logic [`MRTF_HANDLE_W-1:0] I_ALLOC_HANDLE,
  // payload dword forwarded to decoder or scan datapath
  output logic O_XFORM_VALID,
  output logic [`MRTF_DW-1:0] O_XFORM_DW,
  // wide return buffer write
  output logic O_WIDE_VALID,
  output mrtf_pkg::mrtf_wide_t O_WIDE,
  // thread to spawner
  output logic O_THREAD_VALID,
  input wire logic I_THREAD_READY,
  output mrtf_pkg::mrtf_thread_t O_THREAD,
  // release from spawner
  input wire logic I_RELEASE,
  input wire logic [`MRTF_HANDLE_W-1:0] I_RELEASE_HANDLE,
  // status
  output logic O_STATE_LOADED,
  output mrtf_pkg::mrtf_mode_t O_MODE
);
  import mrtf_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_PAYLOAD, ST_FLUSH, ST_SPAWN} mrtf_fsm_t;
  mrtf_fsm_t fsm;
  mrtf_state_t pend;
  mrtf_state_t act;
  logic pend_new;
  logic loaded;
  logic [`MRTF_CNT_W-1:0] alloc_left;
  logic [`MRTF_ADDR_W-1:0] offset;
  logic [`MRTF_HANDLE_W-1:0] cur_handle;
  logic [`MRTF_HANDLE_W-1:0] beat;
  logic [`MRTF_BEAT_IDX_W-1:0] word_idx;
  logic [`MRTF_WIDE_W-1:0] acc;
  logic pool_avail;
  logic [`MRTF_HANDLE_W-1:0] pool_head;
  logic take;
  logic start;
  logic dw_fire;
  logic beat_full;

  // stall without handle
  // handshakes stay low while frozen, so no transfer is accepted and then lost
  assign start = I_CE && I_CMD_VALID && fsm == ST_IDLE && (loaded || pend_new) && pool_avail
                 && alloc_left == 5'h00 && !I_STATE_VALID;
  assign O_CMD_READY = start;
  assign take = start;
  assign O_DW_READY = I_CE && fsm == ST_PAYLOAD;
  assign dw_fire = I_DW_VALID && O_DW_READY;
  assign beat_full = word_idx == 3'h7;
  assign O_ALLOC_REQ = I_CE && alloc_left != 5'h00;
  assign O_STATE_LOADED = loaded;
  assign O_MODE = act.mode;
  assign O_THREAD_VALID = I_CE && fsm == ST_SPAWN;

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      pend <= '0;
      pend_new <= 1'b0;
    end else if (I_CE) begin
      if (I_STATE_VALID) begin
        pend <= I_STATE;
        pend_new <= 1'b1;
      end else if (start) begin
        pend_new <= 1'b0;
      end
    end
  end

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      act <= '0;
      loaded <= 1'b0;
    end else if (I_CE) begin
      if (start && pend_new) begin
        act <= pend;
        loaded <= 1'b1;
      end
    end
  end

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      alloc_left <= 5'h00;
    end else if (I_CE) begin
      if (I_STATE_VALID) begin
        alloc_left <= (I_STATE.handle_count > 5'h10) ? 5'h10 : I_STATE.handle_count;
      end else if (I_ALLOC_VALID && alloc_left != 5'h00) begin
        alloc_left <= alloc_left - 5'h01;
      end
    end
  end

  mrtf_handle_pool u_pool (
    .I_CLK(I_CLK),
    .I_NRST(I_NRST),
    .i_ce(I_CE),
    .i_flush(I_STATE_VALID),
    .i_load_valid(I_ALLOC_VALID && alloc_left != 5'h00),
    .i_load_handle(I_ALLOC_HANDLE),
    .i_take(take),
    .i_release(I_RELEASE),
    .i_release_handle(I_RELEASE_HANDLE),
    .o_avail(pool_avail),
    .o_head_handle(pool_head)
  );

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      fsm <= ST_IDLE;
    end else if (I_CE) begin
      unique case (fsm)
        ST_IDLE: begin
          if (start) begin
            fsm <= ST_PAYLOAD;
          end
        end
        ST_PAYLOAD: begin
          if (dw_fire && I_DW_LAST) begin
            fsm <= ST_FLUSH;
          end
        end
        ST_FLUSH: begin
          fsm <= ST_SPAWN;
        end
        ST_SPAWN: begin
          if (I_THREAD_READY) begin
            fsm <= ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      cur_handle <= 8'h00;
      offset <= 32'h00000000;
    end else if (I_CE && start) begin
      cur_handle <= pool_head;
      offset <= I_CMD_DESC_OFFSET;
    end
  end

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_XFORM_VALID <= 1'b0;
      O_XFORM_DW <= 32'h00000000;
    end else if (I_CE) begin
      O_XFORM_VALID <= dw_fire && act.mode != MRTF_MODE_GENERIC;
      if (dw_fire) begin
        O_XFORM_DW <= I_DW;
      end
    end
  end

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      acc <= '0;
      word_idx <= 3'h0;
      beat <= 8'h00;
      O_WIDE_VALID <= 1'b0;
      O_WIDE <= '0;
    end else if (I_CE) begin
      O_WIDE_VALID <= 1'b0;
      if (start) begin
        acc <= '0;
        word_idx <= 3'h0;
        beat <= 8'h00;
      end else if (dw_fire) begin
        acc[word_idx*`MRTF_DW +: `MRTF_DW] <= I_DW;
        word_idx <= word_idx + 3'h1;
        if (beat_full || I_DW_LAST) begin
          O_WIDE_VALID <= 1'b1;
          O_WIDE.handle <= cur_handle;
          O_WIDE.beat <= beat;
          O_WIDE.data <= acc;
          O_WIDE.data[word_idx*`MRTF_DW +: `MRTF_DW] <= I_DW;
          acc <= '0;
          word_idx <= 3'h0;
          beat <= beat + 8'h01;
        end
      end
    end
  end

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_THREAD <= '0;
    end else if (I_CE && fsm == ST_FLUSH) begin
      O_THREAD.desc_ptr <= act.desc_base + 32'(offset * `MRTF_DESC_SIZE);
      O_THREAD.handle <= cur_handle;
      O_THREAD.const_handle <= act.const_handle;
      O_THREAD.scratch_base <= act.scratch_base;
      O_THREAD.scratch_cfg <= act.scratch_cfg;
    end
  end

  property p_spawn_after_payload;
    @(posedge I_CLK) disable iff (!I_NRST)
      (I_CE && fsm == ST_PAYLOAD && dw_fire && I_DW_LAST) ##1 I_CE ##1 I_CE |-> O_THREAD_VALID;
  endproperty
  a_spawn_after_payload: assert property (p_spawn_after_payload)
    else $error("thread not offered after last dword");

  property p_no_start_without_handle;
    @(posedge I_CLK) disable iff (!I_NRST)
      !pool_avail |-> !O_CMD_READY;
  endproperty
  a_no_start_without_handle: assert property (p_no_start_without_handle)
    else $error("command taken with no free handle");

  property p_desc_ptr;
    @(posedge I_CLK) disable iff (!I_NRST)
      O_THREAD_VALID |-> O_THREAD.desc_ptr == act.desc_base + 32'(offset * `MRTF_DESC_SIZE);
  endproperty
  a_desc_ptr: assert property (p_desc_ptr)
    else $error("descriptor pointer wrong");

  property p_thread_fields;
    @(posedge I_CLK) disable iff (!I_NRST)
      O_THREAD_VALID |-> O_THREAD.handle == cur_handle
        && O_THREAD.const_handle == act.const_handle
        && O_THREAD.scratch_base == act.scratch_base;
  endproperty
  a_thread_fields: assert property (p_thread_fields)
    else $error("thread fields do not match state");

  property p_latch_first;
    @(posedge I_CLK) disable iff (!I_NRST)
      (I_CE && I_STATE_VALID) |=> act == $past(act);
  endproperty
  a_latch_first: assert property (p_latch_first)
    else $error("state latched before primitive");

  property p_alloc_after_state;
    @(posedge I_CLK) disable iff (!I_NRST)
      (I_CE && I_STATE_VALID && I_STATE.handle_count != 5'h00) ##1 I_CE |-> O_ALLOC_REQ;
  endproperty
  a_alloc_after_state: assert property (p_alloc_after_state)
    else $error("no allocation after state change");

  property p_one_dword;
    @(posedge I_CLK) disable iff (!I_NRST)
      (I_CE && dw_fire && act.mode != MRTF_MODE_GENERIC) |=> O_XFORM_VALID
        && O_XFORM_DW == $past(I_DW);
  endproperty
  a_one_dword: assert property (p_one_dword)
    else $error("dword not forwarded to datapath");

  property p_wide_handle;
    @(posedge I_CLK) disable iff (!I_NRST)
      O_WIDE_VALID |-> O_WIDE.handle == cur_handle;
  endproperty
  a_wide_handle: assert property (p_wide_handle)
    else $error("payload written to wrong handle");
endmodule : mrtf_front_end
`default_nettype wire

// >>> testbench/mrtf_partner.sv
// far side model: handle manager, thread spawner and its release path
`default_nettype none
`include "mrtf_params.svh"
module mrtf_partner
  import mrtf_pkg::*;
(
  // clock
  input wire logic i_clk,
  // handle allocation
  input wire logic i_alloc_req,
  output logic o_alloc_valid,
  output logic [`MRTF_HANDLE_W-1:0] o_alloc_handle,
  // thread hand-over
  input wire logic i_thread_valid,
  input wire mrtf_pkg::mrtf_thread_t i_thread,
  output logic o_thread_ready,
  // bench controls
  input wire logic i_slow,
  input wire logic i_rel_go,
  output logic o_release,
  output logic [`MRTF_HANDLE_W-1:0] o_release_handle
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] gen = 8'h10;
  logic [7:0] held[$];
  logic [1:0] ph = 2'h0;
  logic want = 1'b0;
  logic go = 1'b0;
  logic sl = 1'b0;
  initial begin
    o_alloc_valid = 1'b0;
    o_alloc_handle = 8'hFF;
    o_thread_ready = 1'b1;
    o_release = 1'b0;
    o_release_handle = 8'hFF;
  end
  // sampled mid-cycle so the answer never races the bench drive
  always @(negedge i_clk) begin
    want = i_alloc_req && !o_alloc_valid;
    go = i_rel_go;
    sl = i_slow;
    if (i_thread_valid && o_thread_ready)
      held.push_back(i_thread.handle);
  end
  always @(posedge i_clk) begin
    #2;
    // one handle per grant, idle lines toggle
    o_alloc_valid = want;
    o_alloc_handle = want ? gen : ~o_alloc_handle;
    if (want)
      gen = gen + 8'h01;
    ph = ph + 2'h1;
    o_thread_ready = !sl || ph == 2'h0;
    // newest first, so releases come out of order
    o_release = go && held.size() > 0;
    o_release_handle = o_release ? held.pop_back() : ~o_release_handle;
  end
endmodule : mrtf_partner
`default_nettype wire

// >>> testbench/tb_top.sv
// self-checking bench for the front end
`default_nettype none
`include "mrtf_params.svh"
module tb_top
  import mrtf_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {mrtf_mode_t m; logic [31:0] o; int n;} mrtf_row_t;
  logic clk, nrst, ce, st_v, cmd_v, cmd_rdy, dw_v, dw_rdy, dw_last, a_req, a_v;
  logic xf_v, wd_v, th_v, th_rdy, rel, slow, rel_go, loaded;
  logic [31:0] off, dw, xf_dw, lastx;
  logic [7:0] a_h, rel_h;
  mrtf_state_t st;
  mrtf_wide_t wd;
  mrtf_thread_t th;
  mrtf_mode_t o_mode;
  mrtf_thread_t thq[$];
  mrtf_wide_t wq[$];
  int errors = 0, checks_done = 0, nx = 0;
  mrtf_row_t rows[4] = '{'{MRTF_MODE_GENERIC, 32'h0, 1}, '{MRTF_MODE_GENERIC, 32'h5, 9},
    '{MRTF_MODE_INV_SCAN, 32'h3, 2}, '{MRTF_MODE_VAR_LEN, 32'hFF, 8}};

  mrtf_front_end DUT (.I_CLK(clk), .I_NRST(nrst), .I_CE(ce), .I_STATE_VALID(st_v),
    .I_STATE(st), .I_CMD_VALID(cmd_v), .O_CMD_READY(cmd_rdy), .I_CMD_DESC_OFFSET(off),
    .I_DW_VALID(dw_v), .O_DW_READY(dw_rdy), .I_DW(dw), .I_DW_LAST(dw_last),
    .O_ALLOC_REQ(a_req), .I_ALLOC_VALID(a_v), .I_ALLOC_HANDLE(a_h), .O_XFORM_VALID(xf_v),
    .O_XFORM_DW(xf_dw), .O_WIDE_VALID(wd_v), .O_WIDE(wd), .O_THREAD_VALID(th_v),
    .I_THREAD_READY(th_rdy), .O_THREAD(th), .I_RELEASE(rel), .I_RELEASE_HANDLE(rel_h),
    .O_STATE_LOADED(loaded), .O_MODE(o_mode));
  mrtf_partner far_side (.i_clk(clk), .i_alloc_req(a_req), .o_alloc_valid(a_v),
    .o_alloc_handle(a_h), .i_thread_valid(th_v), .i_thread(th), .o_thread_ready(th_rdy),
    .i_slow(slow), .i_rel_go(rel_go), .o_release(rel), .o_release_handle(rel_h));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(negedge clk) begin
    if (th_v === 1'b1 && th_rdy === 1'b1)
      thq.push_back(th);
    if (wd_v === 1'b1)
      wq.push_back(wd);
    if (xf_v === 1'b1) begin
      nx++;
      lastx = xf_dw;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic results();
    $display("errors=%0d checks=%0d", errors, checks_done);
    if (errors == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : results
  task automatic wait_for(input int k);
    for (int i = 0; i < 300; i++) begin
      @(negedge clk);
      if (k == 0 && cmd_rdy === 1'b1 || k == 1 && dw_rdy === 1'b1 || k == 2 && thq.size() > 0)
        return;
    end
    errors++;
    results();
  endtask : wait_for
  task automatic send_state(input mrtf_mode_t m, input logic [31:0] base);
    st = '{m, base, 32'h0000_8000, 32'h0000_0003, 5'h04, 8'h02, 8'h5A};
    st_v = 1'b1;
    @(posedge clk);
    #2 st_v = 1'b0;
    thq.delete();
    wq.delete();
    nx = 0;
  endtask : send_state
  task automatic run_cmd(input logic [31:0] o, input int n);
    thq.delete();
    wq.delete();
    nx = 0;
    off = o;
    // a header already taken while stalled goes straight to its payload
    if (dw_rdy !== 1'b1) begin
      cmd_v = 1'b1;
      wait_for(0);
      @(posedge clk);
      #2;
    end
    cmd_v = 1'b0;
    for (int i = 0; i < n; i++) begin
      dw = 32'hC000_0000 + 32'(i);
      dw_last = 1'(i == n - 1);
      dw_v = 1'b1;
      wait_for(1);
      @(posedge clk);
      #2;
    end
    dw_v = 1'b0;
    dw_last = 1'b0;
    wait_for(2);
    // let the accept edge pass so the next drive starts just after a rising edge
    @(posedge clk);
    #2;
  endtask : run_cmd
  task automatic chk_thread(input logic [31:0] base, input logic [31:0] o,
                            input logic [7:0] h, input int n, input mrtf_mode_t m);
    mrtf_thread_t t;
    chk(32'(thq.size()), 32'h1);
    t = thq.pop_front();
    chk(t.desc_ptr, base + o * `MRTF_DESC_SIZE);
    chk(32'(t.handle), 32'(h));
    chk(32'(t.const_handle), 32'h5A);
    chk(t.scratch_base, 32'h0000_8000);
    chk(t.scratch_cfg, 32'h0000_0003);
    chk(32'(thq.size()), 32'h0);
    chk(32'(wq.size()), 32'((n + 7) / 8));
    chk(32'(wq[$].handle), 32'(h));
    chk(wq[$].data[31:0], 32'hC000_0000 + 32'((n - 1) / 8 * 8));
    chk(32'(wq[$].beat), 32'((n - 1) / 8));
    chk(32'(loaded), 32'h1);
    if (n % 8 == 1)
      chk(wq[$].data[63:32], 32'h0);
    chk(32'(nx), m == MRTF_MODE_GENERIC ? 32'h0 : 32'(n));
    if (m != MRTF_MODE_GENERIC)
      chk(lastx, 32'hC000_0000 + 32'(n - 1));
    chk(32'(o_mode), 32'(m));
  endtask : chk_thread

  initial begin
    {nrst, st_v, cmd_v, dw_v, dw_last, slow, rel_go} = 7'h00;
    ce = 1'b1;
    off = 32'h0;
    dw = 32'h0;
    lastx = 32'h0;
    st = '0;
    repeat (12) @(posedge clk);
    #2 nrst = 1'b1;
    // a command with nothing loaded must wait
    cmd_v = 1'b1;
    repeat (4) @(negedge clk);
    chk(32'({cmd_rdy, loaded, a_req}), 32'h0);
    @(posedge clk);
    #2 cmd_v = 1'b0;
    foreach (rows[j]) begin
      // state is only sent while the unit is idle
      send_state(rows[j].m, 32'h0001_0000);
      // the nine-dword row stands for a long indirect stream
      run_cmd(rows[j].o, rows[j].n);
      chk_thread(32'h0001_0000, rows[j].o, 8'h10 + 8'(4 * j), rows[j].n, rows[j].m);
    end
    // a new state waits for the first command; the old mode stands until then
    send_state(MRTF_MODE_GENERIC, 32'h0002_0000);
    chk(32'(o_mode), 32'(MRTF_MODE_VAR_LEN));
    slow = 1'b1;
    run_cmd(32'h2, 3);
    chk_thread(32'h0002_0000, 32'h2, 8'h20, 3, MRTF_MODE_GENERIC);
    slow = 1'b0;
    for (int k = 1; k < 4; k++) begin
      run_cmd(32'h1, 1);
      chk_thread(32'h0002_0000, 32'h1, 8'h20 + 8'(k), 1, MRTF_MODE_GENERIC);
    end
    // a waiting header shows the stall on its ready line
    off = 32'h7;
    cmd_v = 1'b1;
    repeat (3) @(negedge clk);
    chk(32'(cmd_rdy), 32'h0);
    // head handle is freed last; the waiting header is taken right after it
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      #2 rel_go = 1'b1;
      @(posedge clk);
      #2 rel_go = 1'b0;
      repeat (3) @(negedge clk);
      chk(32'({cmd_rdy, dw_rdy}), k == 3 ? 32'h1 : 32'h0);
    end
    @(posedge clk);
    #2;
    run_cmd(32'h7, 2);
    chk_thread(32'h0002_0000, 32'h7, 8'h20, 2, MRTF_MODE_GENERIC);
    nrst = 1'b0;
    @(posedge clk);
    #2 nrst = 1'b1;
    cmd_v = 1'b1;
    @(negedge clk);
    chk(32'({cmd_rdy, loaded, a_req}), 32'h0);
    results();
  end
endmodule : tb_top
`default_nettype wire
